// *** ol_regs.svh ***
`ifndef OL_REGS_SVH
`define OL_REGS_SVH
// clock rate and open-load deglitch time
`define OL_CLK_MHZ 50
`define OL_DEGLITCH_NS 10000
// least time rounds up to whole cycles
`define OL_DEGLITCH_CYC ((`OL_DEGLITCH_NS * `OL_CLK_MHZ + 999) / 1000)
// reset values
`define OL_FLAG_RST 1'b0
`define OL_PIN_RST 1'b1
`define OL_GATE_RST 1'b0
`define OL_CNT_RST 16'h0000
`endif

// *** ol_pkg.sv ***
`default_nettype none
package ol_pkg;
  typedef logic [15:0] ol_cnt_type;
endpackage
`default_nettype wire

// *** ol_deglitch.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ol_regs.svh"
module ol_deglitch #(
  parameter int CYCLES = `OL_DEGLITCH_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic armed,
  input wire logic below,
  output logic hit
);
  localparam ol_pkg::ol_cnt_type lim = ol_pkg::ol_cnt_type'(CYCLES);
  ol_pkg::ol_cnt_type cnt_reg;
  ol_pkg::ol_cnt_type cnt_next;
  wire logic cond;

  // detector runs only while its transistor conducts
  assign cond = armed & below;
  assign cnt_next = !cond ? `OL_CNT_RST :
                    (cnt_reg == lim) ? lim : cnt_reg + 16'h0001;
  assign hit = (cnt_reg == lim);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_reg <= `OL_CNT_RST;
    else
      cnt_reg <= cnt_next;
  end
endmodule
`default_nettype wire

// *** ol_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ol_regs.svh"
module ol_top #(
  parameter int CH = 12,
  parameter int DEGLITCH_CYC = `OL_DEGLITCH_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic keep_outputs_on_fault,
  input wire logic suppress_pin_report,
  input wire logic neg_current_detect_en,
  input wire logic clear_faults,
  input wire logic [CH-1:0] high_side_drive_en,
  input wire logic [CH-1:0] low_side_drive_en,
  input wire logic [CH-1:0] open_detect_disable,
  input wire logic [CH-1:0] low_current_detect_en,
  input wire logic [CH/2-1:0] full_bridge_pair,
  input wire logic [CH-1:0] hs_below_pin,
  input wire logic [CH-1:0] ls_below_pin,
  input wire logic [CH-1:0] ls_below_low_pin,
  input wire logic [CH-1:0] reverse_pin,
  input wire logic [CH-1:0] reverse_below_neg_pin,
  output logic [CH-1:0] hs_gate_on,
  output logic [CH-1:0] ls_gate_on,
  output logic [CH-1:0] ls_low_thresh_sel,
  output logic [CH-1:0] ls_ocp_reduce,
  output logic [CH-1:0] high_side_open_flag,
  output logic [CH-1:0] low_side_open_flag,
  output logic open_load_summary_flag,
  output logic fault_pin_n
);
  // pick the comparator that qualifies a detector this cycle
  function automatic logic meas_sel(input logic neg, input logic rev,
                                    input logic below_neg,
                                    input logic below_norm);
    meas_sel = (neg & rev) ? below_neg : below_norm;
  endfunction

  // comparator outputs come from the analog side, so double-sync them
  logic [CH-1:0] hs_s1_reg, hs_s2_reg;
  logic [CH-1:0] ls_s1_reg, ls_s2_reg;
  logic [CH-1:0] lo_s1_reg, lo_s2_reg;
  logic [CH-1:0] rv_s1_reg, rv_s2_reg;
  logic [CH-1:0] ng_s1_reg, ng_s2_reg;
  logic [CH-1:0] hs_flag_reg, ls_flag_reg, hs_flag_next, ls_flag_next;
  logic [CH-1:0] hs_gate_reg, ls_gate_reg, hs_gate_next, ls_gate_next;
  logic sum_reg, sum_next, pin_reg, pin_next;
  logic [CH-1:0] hs_hit, ls_hit, hs_armed, ls_armed, hs_meas, ls_meas;
  logic [CH-1:0] hs_set, ls_set, blocked, tristate, chan_flag, chan_hit;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hs_s1_reg <= '0;
      hs_s2_reg <= '0;
      ls_s1_reg <= '0;
      ls_s2_reg <= '0;
      lo_s1_reg <= '0;
      lo_s2_reg <= '0;
      rv_s1_reg <= '0;
      rv_s2_reg <= '0;
      ng_s1_reg <= '0;
      ng_s2_reg <= '0;
    end
    else
    begin
      hs_s1_reg <= hs_below_pin;
      hs_s2_reg <= hs_s1_reg;
      ls_s1_reg <= ls_below_pin;
      ls_s2_reg <= ls_s1_reg;
      lo_s1_reg <= ls_below_low_pin;
      lo_s2_reg <= lo_s1_reg;
      rv_s1_reg <= reverse_pin;
      rv_s2_reg <= rv_s1_reg;
      ng_s1_reg <= reverse_below_neg_pin;
      ng_s2_reg <= ng_s1_reg;
    end
  end

  assign chan_flag = hs_flag_reg | ls_flag_reg;
  assign chan_hit = hs_hit | ls_hit;

  genvar i;
  generate
    for (i = 0; i < CH; i = i + 1)
    begin : g_ch
      // disable bits default low, so detection arms once the channel's gate register turns on and, for the high side, low-current mode is off
      assign hs_armed[i] = hs_gate_reg[i] & ~open_detect_disable[i] &
                           ~low_current_detect_en[i];
      assign ls_armed[i] = ls_gate_reg[i] & ~open_detect_disable[i];
      // with negative mode off a reverse current still reads as below
      assign hs_meas[i] = meas_sel(neg_current_detect_en, rv_s2_reg[i],
                                   ng_s2_reg[i], hs_s2_reg[i]);
      assign ls_meas[i] = low_current_detect_en[i] ? lo_s2_reg[i] :
                          meas_sel(neg_current_detect_en, rv_s2_reg[i],
                                   ng_s2_reg[i], ls_s2_reg[i]);
      assign ls_low_thresh_sel[i] = low_current_detect_en[i];
      assign ls_ocp_reduce[i] = low_current_detect_en[i];
      // partner already flagged, or both at once: even channel wins
      assign blocked[i] = full_bridge_pair[i/2] &
                          (chan_flag[i ^ 1] |
                           (chan_hit[i ^ 1] & (i % 2 == 1)));
      assign tristate[i] = ~keep_outputs_on_fault &
                           (chan_flag[i] |
                            (full_bridge_pair[i/2] &
                             chan_flag[i ^ 1]));

      ol_deglitch #(.CYCLES(DEGLITCH_CYC)) u_hs (
        .clk(clk),
        .sys_rst(sys_rst),
        .armed(hs_armed[i]),
        .below(hs_meas[i]),
        .hit(hs_hit[i])
      );
      ol_deglitch #(.CYCLES(DEGLITCH_CYC)) u_ls (
        .clk(clk),
        .sys_rst(sys_rst),
        .armed(ls_armed[i]),
        .below(ls_meas[i]),
        .hit(ls_hit[i])
      );
    end
  endgenerate

  assign hs_set = hs_hit & ~blocked;
  assign ls_set = ls_hit & ~blocked;
  // set wins; clear only drops flags whose detector no longer sees it
  assign hs_flag_next = hs_set |
                        (hs_flag_reg &
                         ~({CH{clear_faults}} & ~hs_hit));
  assign ls_flag_next = ls_set |
                        (ls_flag_reg &
                         ~({CH{clear_faults}} & ~ls_hit));
  assign sum_next = (|(hs_set | ls_set)) |
                    (sum_reg & ~(clear_faults &
                     ~(|(hs_flag_next | ls_flag_next))));
  assign pin_next = ~(sum_next & ~suppress_pin_report);
  // keeping outputs trades protection for uninterrupted drive
  assign hs_gate_next = high_side_drive_en & ~tristate;
  assign ls_gate_next = low_side_drive_en & ~tristate;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hs_flag_reg <= {CH{`OL_FLAG_RST}};
      ls_flag_reg <= {CH{`OL_FLAG_RST}};
      hs_gate_reg <= {CH{`OL_GATE_RST}};
      ls_gate_reg <= {CH{`OL_GATE_RST}};
      sum_reg <= `OL_FLAG_RST;
      pin_reg <= `OL_PIN_RST;
    end
    else
    begin
      hs_flag_reg <= hs_flag_next;
      ls_flag_reg <= ls_flag_next;
      hs_gate_reg <= hs_gate_next;
      ls_gate_reg <= ls_gate_next;
      sum_reg <= sum_next;
      pin_reg <= pin_next;
    end
  end

  assign hs_gate_on = hs_gate_reg;
  assign ls_gate_on = ls_gate_reg;
  assign high_side_open_flag = hs_flag_reg;
  assign low_side_open_flag = ls_flag_reg;
  assign open_load_summary_flag = sum_reg;
  assign fault_pin_n = pin_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_tristate_on_fault: assert property (
    (chan_flag[0] && !keep_outputs_on_fault) |=>
      (!hs_gate_on[0] && !ls_gate_on[0]))
    else $error("faulted channel still driving");
  chk_keep_drive: assert property (
    (keep_outputs_on_fault && high_side_drive_en[0]) |=> hs_gate_on[0])
    else $error("keep mode dropped commanded drive");
  chk_pin_report: assert property (
    ##1 fault_pin_n ==
      !(open_load_summary_flag && !$past(suppress_pin_report)))
    else $error("fault pin disagrees with summary and suppress");
  chk_pair_one_side: assert property (
    (full_bridge_pair[0] && $past(full_bridge_pair[0]) &&
     !$past(chan_flag[0] && chan_flag[1])) |->
      !(chan_flag[0] && chan_flag[1]))
    else $error("both sides of a pair flagged");
  chk_summary_sticky: assert property (
    (open_load_summary_flag && !clear_faults) |=> open_load_summary_flag)
    else $error("summary dropped without clear");
  chk_flag_holds: assert property (
    (hs_flag_reg[0] && !(clear_faults && !hs_hit[0])) |=> hs_flag_reg[0])
    else $error("flag dropped while condition or no clear");
  chk_hit_needs_gate: assert property (
    $rose(hs_hit[0]) |-> $past(hs_gate_reg[0]))
    else $error("detector fired with transistor off");
  chk_lowcur_hs_off: assert property (
    low_current_detect_en[0] |=> !hs_hit[0])
    else $error("high-side detection live in low-current mode");
  chk_clear_frees: assert property (
    (clear_faults && !chan_hit[0] && !hs_set[0]) |=> !hs_flag_reg[0])
    else $error("clear left a resolved flag set");

  cov_hs_flag: cover property ($rose(hs_flag_reg[0]));
  cov_ls_lowcur: cover property (low_current_detect_en[0] &&
                                 $rose(ls_flag_reg[0]));
  cov_summary_clear: cover property ($fell(open_load_summary_flag));
  cov_pair_fault: cover property (full_bridge_pair[0] &&
                                  $rose(chan_flag[1]));
endmodule
`default_nettype wire

// *** ol_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ol_host #(
  parameter int DG = 4
) (
  input wire logic clk,
  input wire logic fault_pin_n,
  input wire logic open_load_summary_flag,
  output logic keep,
  output logic supp,
  output logic neg,
  output logic clr,
  output logic [1:0] hs_en,
  output logic [1:0] ls_en,
  output logic [1:0] dis,
  output logic [1:0] lc_en,
  output logic pair
);
  initial {keep, supp, neg, clr, hs_en, ls_en, dis, lc_en, pair} = '0;
  task cfg(input logic k, input logic s, input logic n,
    input logic [1:0] h, input logic [1:0] l, input logic [1:0] d,
    input logic [1:0] c, input logic p);
    @(negedge clk);
    {keep, supp, neg, hs_en} = {k, s, n, h};
    {ls_en, dis, lc_en, pair} = {l, d, c, p};
  endtask
  // one rising edge sees the command, then it drops
  task pulse_clear;
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
  endtask
  task confirm(output logic hit);
    cfg(1'b1, 1'b0, 1'b0, 2'h0, 2'h1, 2'h0, 2'h0, 1'b0);
    repeat (DG + 4) @(negedge clk);
    // no high-side output is driven here, so nothing to disable
    cfg(1'b1, 1'b0, 1'b0, 2'h0, 2'h1, 2'h0, 2'h1, 1'b0);
    repeat (DG + 4) @(negedge clk);
    pulse_clear();
    @(negedge clk);
    hit = (fault_pin_n === 1'b0) &&
          (open_load_summary_flag === 1'b1);
  endtask
endmodule
`default_nettype wire

// *** ol_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ol_top_tb;
  localparam int DG = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic keep, supp, neg, clr, pair, hit;
  logic [1:0] hs_en, ls_en, dis, lc_en, hs_g, ls_g, lsel, locp, hf, lf;
  logic [1:0] hs_b = 2'h0, ls_b = 2'h0, ls_lo = 2'h0, rev = 2'h0;
  logic [1:0] rev_n = 2'h0;
  logic summ, pin;
  logic [9:0] exp_q[$];
  event look;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 89733;
  wire logic [9:0] obs = {summ, pin, hf, lf, hs_g, ls_g};
  ol_top #(.CH(2), .DEGLITCH_CYC(DG)) ol_top_i (.clk(clk), .sys_rst(sys_rst),
    .keep_outputs_on_fault(keep), .suppress_pin_report(supp),
    .neg_current_detect_en(neg), .clear_faults(clr),
    .high_side_drive_en(hs_en), .low_side_drive_en(ls_en),
    .open_detect_disable(dis), .low_current_detect_en(lc_en),
    .full_bridge_pair(pair), .hs_below_pin(hs_b), .ls_below_pin(ls_b),
    .ls_below_low_pin(ls_lo), .reverse_pin(rev),
    .reverse_below_neg_pin(rev_n), .hs_gate_on(hs_g), .ls_gate_on(ls_g),
    .ls_low_thresh_sel(lsel), .ls_ocp_reduce(locp),
    .high_side_open_flag(hf), .low_side_open_flag(lf),
    .open_load_summary_flag(summ), .fault_pin_n(pin));
  ol_host #(.DG(DG)) ol_host_i (.clk(clk), .fault_pin_n(pin),
    .open_load_summary_flag(summ), .keep(keep), .supp(supp), .neg(neg),
    .clr(clr), .hs_en(hs_en), .ls_en(ls_en), .dis(dis), .lc_en(lc_en),
    .pair(pair));
  initial forever #10 clk = ~clk;
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [9:0] seen, input logic [9:0] want);
    n_checks++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  // flag lands deglitch plus three edges after the pin, gates one later
  task expect_after(input int n, input logic [9:0] want);
    repeat (n) @(negedge clk);
    exp_q.push_back(want);
    ->look;
  endtask
  task cleanup;
    @(negedge clk) {hs_b, ls_b, ls_lo, rev, rev_n} = '0;
    repeat (4) @(negedge clk);
    ol_host_i.pulse_clear();
    ol_host_i.cfg(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0);
  endtask
  initial forever
  begin
    @(look);
    #1 chk(obs, exp_q.pop_front());
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial
  begin
    logic k, f, ls;
    int m;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      k = i[0];
      ol_host_i.cfg(k, i[1], 1'b0, 2'h1, 2'h0, 2'h0, 2'h0, 1'b0);
      hs_b = 2'h1;
      expect_after(DG + 5,
        {1'b1, i[1], 2'h1, 2'h0, {1'b0, k}, 2'h0});
      if (k)
      begin
        ol_host_i.pulse_clear();
        expect_after(2, {1'b1, i[1], 2'h1, 2'h0, 2'h1, 2'h0});
      end
      hs_b = 2'h0;
      repeat (4) @(negedge clk);
      ol_host_i.pulse_clear();
      expect_after(2, {1'b0, 1'b1, 2'h0, 2'h0, 2'h1, 2'h0});
      cleanup();
    end
    ol_host_i.cfg(1'b0, 1'b0, 1'b0, 2'h1, 2'h2, 2'h0, 2'h0, 1'b1);
    {hs_b, ls_b} = {2'h1, 2'h2};
    expect_after(DG + 5, {1'b1, 1'b0, 2'h1, 2'h0, 2'h0, 2'h0});
    cleanup();
    // random comparator noise on undriven or disabled channels
    ol_host_i.cfg(1'b0, 1'b0, 1'b0, 2'h1, 2'h0, 2'h1, 2'h0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      {ls_b, ls_lo, rev, rev_n} = 8'($random(seed));
      hs_b = {1'($random(seed)), 1'b1};
      expect_after(DG + 5, {1'b0, 1'b1, 2'h0, 2'h0, 2'h1, 2'h0});
    end
    cleanup();
    for (int j = 0; j < 6; j++)
    begin
      ls = (j >= 3);
      m = j % 3;
      f = (m != 1);
      ol_host_i.cfg(1'b1, 1'b0, m != 0, {1'b0, !ls}, {1'b0, ls}, 2'h0,
        2'h0, 1'b0);
      {hs_b, ls_b, rev, rev_n} = {2'h1, 2'h1, 2'h1, {1'b0, m == 2}};
      expect_after(DG + 5, {f, !f, {1'b0, f & !ls}, {1'b0, f & ls},
        {1'b0, !ls}, {1'b0, ls}});
      cleanup();
    end
    {ls_b, ls_lo} = {2'h1, 2'h1};
    ol_host_i.confirm(hit);
    chk({9'h0, hit}, 10'h1);
    chk({6'h0, lsel, locp}, {6'h0, 2'h1, 2'h1});
    expect_after(0, {1'b1, 1'b0, 2'h0, 2'h1, 2'h0, 2'h1});
    cleanup();
    // channel 1 low side trips only the low comparator
    ol_host_i.cfg(1'b1, 1'b0, 1'b0, 2'h1, 2'h2, 2'h0, 2'h3, 1'b0);
    {hs_b, ls_lo} = {2'h1, 2'h2};
    expect_after(DG + 5,
      {1'b1, 1'b0, 2'h0, 2'h2, 2'h1, 2'h2});
    chk({6'h0, lsel, locp}, 10'h00f);
    repeat (2) @(negedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
